// >>> verilog/fft_mode_control_decode.v
// Mode control register of the FFT processor, its decode, load and dump
// sequencing flags, and on-the-fly window weighting of loaded samples.
// Assumes the strobe, aux and sample pins are asynchronous to clk_in; strobes are active high.
`include "fft_mode_consts.vh"
module fft_mode_control_decode (
    input  wire        clk_in,                   // System clock
    input  wire        rst_in,                   // Synchronous reset
    input  wire        mode_define_strobe_in,    // Mode define strobe
    input  wire [15:0] imaginary_aux_in,         // Aux pins, mode word
    input  wire        input_load_enable_in,     // Load enable
    input  wire        input_sample_strobe_in,   // Input strobe
    input  wire        output_sample_strobe_in,  // Output strobe
    input  wire [15:0] sample_in,                // Real sample
    input  wire        weighted_ready_in,        // Consumer ready
    output reg  [15:0] weighted_sample_out,      // Windowed sample
    output reg         weighted_valid_out,       // Windowed valid
    output reg         load_window_flag_out,     // Load flag
    output reg         output_valid_flag_out,    // Output valid
    output reg         output_drive_enable_out,  // Output drivers on
    output reg  [9:0]  dump_index_out,           // Bin being dumped
    output reg  [2:0]  size_code_out,            // Size and type
    output reg         real_data_out,            // Real transform
    output reg  [1:0]  later_pass_shift_out,     // Shifts after pass 1
    output reg         inverse_out,              // Inverse transform
    output reg  [1:0]  window_sel_out,           // Window choice
    output reg  [1:0]  overlap_out,              // 0 none,1 50%,2 75%
    output reg         dual_source_out,          // Dual real source
    output reg  [1:0]  system_config_out,        // System config
    output reg         sequential_out,           // Forced sequential
    output reg         test_mode_out,            // Internal test mode
    output reg  [1:0]  dump_size_out             // Dump size code
);
    localparam PW = 36;

    // Block length as log2 of points per window
    function [3:0] blk_lg;
        input [2:0] sz;
        begin
            case (sz)
                3'h1, 3'h4: blk_lg = 4'h6;
                3'h2, 3'h5: blk_lg = 4'h8;
                3'h3, 3'h6: blk_lg = 4'ha;
                default: blk_lg = 4'h4;
            endcase
        end
    endfunction

    // Quarter-wave cosine table, 64 points per cycle
    function [15:0] qtab;
        input [4:0] i;
        begin
            case (i)
                5'h00: qtab = 16'h7fff;
                5'h01: qtab = 16'h7f62;
                5'h02: qtab = 16'h7d8a;
                5'h03: qtab = 16'h7a7d;
                5'h04: qtab = 16'h7642;
                5'h05: qtab = 16'h70e3;
                5'h06: qtab = 16'h6a6e;
                5'h07: qtab = 16'h62f2;
                5'h08: qtab = 16'h5a82;
                5'h09: qtab = 16'h5134;
                5'h0a: qtab = 16'h471d;
                5'h0b: qtab = 16'h3c57;
                5'h0c: qtab = 16'h30fc;
                5'h0d: qtab = 16'h2528;
                5'h0e: qtab = 16'h18f9;
                5'h0f: qtab = 16'h0c8c;
                default: qtab = 16'h0000;
            endcase
        end
    endfunction

    // Signed cosine of a 6-bit phase
    function signed [16:0] cos64;
        input [5:0] p;
        reg [4:0]  mi;
        reg [16:0] mag;
        begin
            mi = p[4] ? (5'h10 - {1'b0, p[3:0]}) : {1'b0, p[3:0]};
            mag = {1'b0, qtab(mi)};
            cos64 = (p[5] ^ p[4]) ? -mag : mag;
        end
    endfunction

    // Window coefficient A - B cos x + C cos 2x, clamped to Q1.15
    function [15:0] coef;
        input [1:0] ws;
        input [5:0] ph;
        reg [15:0] a;
        reg [15:0] b;
        reg [15:0] c;
        reg signed [33:0] s;
        begin
            a = `COEF_ONE;
            b = 16'h0000;
            c = 16'h0000;
            case (ws)
                `WIN_HAM: begin
                    a = `HAM_A;
                    b = `HAM_B;
                end
                `WIN_BH: begin
                    a = `BH_A;
                    b = `BH_B;
                    c = `BH_C;
                end
                default: a = `COEF_ONE;
            endcase
            s = $signed({3'h0, a, 15'h0000})
                - $signed({1'b0, b}) * cos64(ph)
                + $signed({1'b0, c}) * cos64({ph[4:0], 1'b0});
            if ((ws != `WIN_HAM) && (ws != `WIN_BH)) begin
                coef = `COEF_ONE;
            end else if (s < 0) begin
                coef = 16'h0000;
            end else if (s[33:30] != 4'h0 || s[30:15] > 16'h7fff) begin
                coef = `COEF_ONE;
            end else begin
                coef = s[30:15];
            end
        end
    endfunction

    // Three-stage pin synchroniser; a bit changes once stages 2 and 3 agree
    wire [PW-1:0] pins = {mode_define_strobe_in, input_load_enable_in,
                          input_sample_strobe_in, output_sample_strobe_in,
                          imaginary_aux_in, sample_in};
    reg  [PW-1:0] p1;
    reg  [PW-1:0] p2;
    reg  [PW-1:0] p3;
    reg  [PW-1:0] pq;
    reg  [PW-1:0] pq_d;
    wire [PW-1:0] agree = ~(p2 ^ p3);

    always @(posedge clk_in) begin
        if (rst_in) begin
            p1   <= {PW{1'b0}};
            p2   <= {PW{1'b0}};
            p3   <= {PW{1'b0}};
            pq   <= {PW{1'b0}};
            pq_d <= {PW{1'b0}};
        end else begin
            p1   <= pins;
            p2   <= p1;
            p3   <= p2;
            pq   <= (p3 & agree) | (pq & ~agree);
            pq_d <= pq;
        end
    end

    // Clean pin levels and rising edges
    wire        def_q   = pq[35];
    wire        ld_q    = pq[34];
    wire        def_rise = pq[35] & ~pq_d[35];
    wire        ld_rise = pq[34] & ~pq_d[34];
    wire        is_rise = pq[33] & ~pq_d[33];
    wire        os_rise = pq[32] & ~pq_d[32];
    wire [15:0] aux_q   = pq[31:16];
    wire [15:0] smp_q   = pq[15:0];

    reg [15:0] mode;
    always @(posedge clk_in) begin
        if (rst_in) begin
            mode <= `MODE_RESET;
        end else if (def_q) begin
            mode <= aux_q;
        end
    end

    // Field decode used by the sequencing logic
    wire [2:0]  sz     = mode[`F_SIZE];
    wire [1:0]  win    = mode[`F_WIN];
    wire [2:0]  ovl    = mode[`F_OVL];
    wire [1:0]  cfg    = mode[`F_CFG];
    wire [3:0]  lg     = blk_lg(sz);
    wire [10:0] blk_n  = 11'h001 << lg;
    wire [10:0] blk_m  = blk_n - 11'h001;
    wire        single = (cfg == `CFG_SINGLE);
    wire        lvl    = mode[`B_LDLVL] & single;
    wire        big    = (sz == `SZ_1K_C) | (sz == `SZ_1K_R);
    wire        seq    = big | (cfg == `CFG_SEQ);
    wire        ov50   = (ovl == 3'h1) | (ovl == 3'h2) | (ovl == 3'h6);
    wire        ov75   = (ovl == 3'h3) | (ovl == 3'h4) | (ovl == 3'h7);
    wire        special = (cfg == `CFG_SPECIAL) & ~big;
    wire [10:0] extra  = ~special ? 11'h000 :
                         ov50 ? (blk_n >> 1) :
                         ov75 ? (blk_n >> 2) : 11'h000;
    wire [10:0] load_last = blk_n + extra - 11'h001;

    // Registered decode outputs
    always @(posedge clk_in) begin
        if (rst_in) begin
            size_code_out        <= 3'h0;
            real_data_out        <= 1'b0;
            later_pass_shift_out <= 2'h3;
            inverse_out          <= 1'b0;
            window_sel_out       <= 2'h0;
            overlap_out          <= 2'h0;
            dual_source_out      <= 1'b0;
            system_config_out    <= 2'h0;
            sequential_out       <= 1'b0;
            test_mode_out        <= 1'b0;
            dump_size_out        <= 2'h0;
        end else begin
            size_code_out        <= sz;
            real_data_out        <= sz[2];
            later_pass_shift_out <= mode[`B_SCALE] ? 2'h2 : 2'h3;
            inverse_out          <= (win == `WIN_INV);
            window_sel_out       <= win;
            overlap_out          <= ov75 ? 2'h2 : (ov50 ? 2'h1 : 2'h0);
            dual_source_out      <= ovl[2] & (ovl != 3'h4);
            system_config_out    <= cfg;
            sequential_out       <= seq;
            test_mode_out        <= (sz == `SZ_16X16) & (win != `WIN_RECT);
            dump_size_out        <= mode[`F_DUMP];
        end
    end

    wire [1:0] div_last = (ovl == 3'h2) ? 2'h1 :
                          (ovl == 3'h4) ? 2'h3 : 2'h0;
    reg  [1:0] div_cnt;
    wire       take_slot = is_rise & (div_cnt == div_last);
    always @(posedge clk_in) begin
        if (rst_in) begin
            div_cnt <= 2'h0;
        end else if (is_rise) begin
            div_cnt <= take_slot ? 2'h0 : div_cnt + 2'h1;
        end
    end

    // Load sequencing state
    reg         loading;
    reg  [10:0] ld_cnt;
    reg         dumping;
    reg         held;
    reg  [4:0]  dav_wait;
    reg  [10:0] dmp_cnt;
    wire        fifo_rdy;
    wire        take = loading & take_slot & fifo_rdy & (~lvl | ld_q);
    wire        last_take = take & (ld_cnt == load_last);
    wire        overwrite = ld_rise | (lvl & ld_q);
    wire        start_req = lvl ? ld_q :
                            (ld_rise | ((aux_q[`F_CFG] != `CFG_SINGLE) & aux_q[`B_LDLVL] & def_rise));
    wire        blocked = seq & (dumping | (held & ~overwrite));
    // Define refuses loads, except its own rising edge
    wire        start = start_req & ~loading & ~blocked & (~def_q | def_rise);

    always @(posedge clk_in) begin
        if (rst_in) begin
            loading              <= 1'b0;
            ld_cnt               <= 11'h000;
            load_window_flag_out <= 1'b0;
        end else if (start) begin
            loading              <= 1'b1;
            ld_cnt               <= 11'h000;
            load_window_flag_out <= 1'b1;
        end else if (take) begin
            ld_cnt <= ld_cnt + 11'h001;
            // flag drops after a normal block
            if (ld_cnt == blk_m) begin
                load_window_flag_out <= 1'b0;
            end
            if (last_take) begin
                loading <= 1'b0;
            end
        end
    end

    // Window phase from the sample index within the block
    wire [9:0]  win_idx = ld_cnt[9:0] & blk_m[9:0];
    wire [15:0] ph_w    = {win_idx, 6'h00} >> lg;
    wire [15:0] coef_w  = coef(win, ph_w[5:0]);

    // Dump range
    wire [1:0]  dsz = mode[`F_DUMP];
    wire [10:0] dump_len = (dsz == 2'h0) ? (blk_n >> 2) :
                           (dsz == 2'h3) ? blk_n : (blk_n >> 1);
    wire [10:0] dump_base = (dsz == `DUMP_LAST) ? (blk_n >> 1) : 11'h000;
    wire [10:0] next_index = dump_base + dmp_cnt + 11'h001;

    // Dump sequencing, valid flag and output drivers
    always @(posedge clk_in) begin
        if (rst_in) begin
            dumping                 <= 1'b0;
            held                    <= 1'b0;
            dmp_cnt                 <= 11'h000;
            dav_wait                <= 5'h00;
            dump_index_out          <= 10'h000;
            output_valid_flag_out   <= 1'b0;
            output_drive_enable_out <= 1'b0;
        end else if (last_take) begin
            dumping                 <= 1'b1;
            held                    <= 1'b0;
            dmp_cnt                 <= 11'h000;
            dump_index_out          <= dump_base[9:0];
            output_drive_enable_out <= 1'b1;
            output_valid_flag_out   <= ~mode[`B_DAVDLY];
            dav_wait <= mode[`B_DAVDLY] ? `DAV_DELAY : 5'h00;
        end else if (dumping & os_rise) begin
            dmp_cnt        <= dmp_cnt + 11'h001;
            dump_index_out <= next_index[9:0];
            if (dav_wait != 5'h00) begin
                dav_wait <= dav_wait - 5'h01;
            end
            if (dav_wait == 5'h01) begin
                output_valid_flag_out <= 1'b1;
            end
            if (dmp_cnt == dump_len - 11'h001) begin
                dumping <= 1'b0;
                if (mode[`B_HOLD]) begin
                    held                  <= 1'b1;
                    output_valid_flag_out <= 1'b1;
                end else begin
                    output_valid_flag_out   <= 1'b0;
                    output_drive_enable_out <= 1'b0;
                end
            end
        end else if (held & overwrite) begin
            held                    <= 1'b0;
            output_valid_flag_out   <= 1'b0;
            output_drive_enable_out <= 1'b0;
        end
    end

    // Sample FIFO between load and weighting output
    wire        f_valid;
    wire [31:0] f_data;
    wire        f_pop = f_valid & (~weighted_valid_out | weighted_ready_in);

    sample_fifo #(
        .WIDTH (`FIFO_WIDTH),
        .DEPTH (`FIFO_DEPTH),
        .AW    (`FIFO_AW)
    ) sample_fifo_i (
        .clk_in       (clk_in),
        .rst_in       (rst_in),
        .wr_valid_in  (take),
        .wr_data_in   ({smp_q, coef_w}),
        .wr_ready_out (fifo_rdy),
        .rd_valid_out (f_valid),
        .rd_data_out  (f_data),
        .rd_ready_in  (f_pop)
    );

    wire signed [32:0] prod = $signed(f_data[31:16]) *
                              $signed({1'b0, f_data[15:0]});

    always @(posedge clk_in) begin
        if (rst_in) begin
            weighted_sample_out <= 16'h0000;
            weighted_valid_out  <= 1'b0;
        end else if (f_pop) begin
            weighted_sample_out <= prod[30:15];
            weighted_valid_out  <= 1'b1;
        end else if (weighted_ready_in) begin
            weighted_valid_out  <= 1'b0;
        end
    end
endmodule // fft_mode_control_decode

// >>> verilog/fft_mode_consts.vh
`ifndef FFT_MODE_CONSTS_VH
`define FFT_MODE_CONSTS_VH
// Constants for the FFT mode control register, its decode and windowing
// Assumes one 10 MHz system clock; included by the design modules

// Mode word reset value and field positions
`define MODE_RESET   16'h0000
`define F_SIZE       2:0
`define B_SCALE      3
`define F_WIN        5:4
`define F_OVL        8:6
`define F_CFG        10:9
`define B_DAVDLY     11
`define B_LDLVL      12
`define F_DUMP       14:13
`define B_HOLD       15

// Field encodings
`define SZ_16X16     3'h0
`define SZ_1K_C      3'h3
`define SZ_1K_R      3'h6
`define WIN_RECT     2'h0
`define WIN_HAM      2'h1
`define WIN_BH       2'h2
`define WIN_INV      2'h3
`define CFG_SINGLE   2'h0
`define CFG_SEQ      2'h2
`define CFG_SPECIAL  2'h3
`define DUMP_LAST    2'h2

// Output strobes between data valid and the valid flag
`define DAV_DELAY    5'h18

// Window coefficients in Q1.15
`define HAM_A        16'h451f
`define HAM_B        16'h3ae1
`define BH_A         16'h362c
`define BH_B         16'h3fb0
`define BH_C         16'h0a24
`define COEF_ONE     16'h7fff

// Sample FIFO geometry
`define FIFO_WIDTH   32
`define FIFO_DEPTH   8
`define FIFO_AW      3
`endif

// >>> verilog/sample_fifo.v
// Synchronous FIFO holding sample and window-coefficient entries between load and output
// Assumes one clock and a synchronous active-high reset
`include "fft_mode_consts.vh"
module sample_fifo #(
    parameter WIDTH = `FIFO_WIDTH,
    parameter DEPTH = `FIFO_DEPTH,
    parameter AW    = `FIFO_AW
) (
    input  wire             clk_in,    // System clock
    input  wire             rst_in,    // Synchronous reset
    input  wire             wr_valid_in, // Entry offered
    input  wire [WIDTH-1:0] wr_data_in,  // Entry data
    output wire             wr_ready_out, // Space available
    output wire             rd_valid_out, // Entry available
    output wire [WIDTH-1:0] rd_data_out,  // Oldest entry
    input  wire             rd_ready_in   // Entry taken
);
    reg [WIDTH-1:0] mem [0:DEPTH-1];
    reg [AW-1:0]    wr_ptr;
    reg [AW-1:0]    rd_ptr;
    reg [AW:0]      count;
    wire            push = wr_valid_in & wr_ready_out;
    wire            pop = rd_valid_out & rd_ready_in;

    // Honest full and empty from the fill count
    assign wr_ready_out = (count != DEPTH[AW:0]);
    assign rd_valid_out = (count != {(AW+1){1'b0}});
    assign rd_data_out  = mem[rd_ptr];

    // Storage write
    always @(posedge clk_in) begin
        if (push) begin
            mem[wr_ptr] <= wr_data_in;
        end
    end

    // Pointers and count
    always @(posedge clk_in) begin
        if (rst_in) begin
            wr_ptr <= {AW{1'b0}};
            rd_ptr <= {AW{1'b0}};
            count  <= {(AW+1){1'b0}};
        end else begin
            if (push) begin
                wr_ptr <= wr_ptr + 1'b1;
            end
            if (pop) begin
                rd_ptr <= rd_ptr + 1'b1;
            end
            if (push & ~pop) begin
                count <= count + 1'b1;
            end else if (pop & ~push) begin
                count <= count - 1'b1;
            end
        end
    end
endmodule // sample_fifo

// >>> testbench/fft_mode_control_decode_chk.sv
// Checker of the mode register decode and output flags of the FFT block
// Assumes only the block's ports; attached by the bind at the foot
module fft_mode_control_decode_chk (
    input wire logic        clk_in,                  // System clock
    input wire logic        rst_in,                  // Synchronous reset
    input wire logic        mode_define_strobe_in,   // Define strobe
    input wire logic [15:0] imaginary_aux_in,        // Aux pins
    input wire logic        load_window_flag_out,    // Load flag
    input wire logic        output_valid_flag_out,   // Output valid
    input wire logic        output_drive_enable_out, // Drivers on
    input wire logic [9:0]  dump_index_out,          // Dump index
    input wire logic [2:0]  size_code_out,           // Size code
    input wire logic        real_data_out,           // Real transform
    input wire logic [1:0]  later_pass_shift_out,    // Shift count
    input wire logic        inverse_out,             // Inverse
    input wire logic [1:0]  window_sel_out,          // Window
    input wire logic [1:0]  overlap_out,             // Overlap
    input wire logic        dual_source_out,         // Dual source
    input wire logic [1:0]  system_config_out,       // Config
    input wire logic        sequential_out,          // Sequential
    input wire logic        test_mode_out,           // Test mode
    input wire logic [1:0]  dump_size_out            // Dump size
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking @(posedge clk_in); endclocking
    default disable iff (rst_in);
    logic [9:0] half_n;
    wire  [2:0] ovl = imaginary_aux_in[8:6];
    // Half the block length for the size in force
    always_comb begin
        case (size_code_out)
            3'h1, 3'h4: half_n = 10'h020;
            3'h2, 3'h5: half_n = 10'h080;
            3'h3, 3'h6: half_n = 10'h200;
            default:    half_n = 10'h008;
        endcase
    end
    // Define held long enough with a steady word
    sequence def_hold;
        (mode_define_strobe_in && $stable(imaginary_aux_in)) [*8];
    endsequence
    chk_mode_capture: assert property (
        def_hold |-> {dump_size_out, system_config_out, window_sel_out, size_code_out} ==
        {imaginary_aux_in[14:13], imaginary_aux_in[10:9], imaginary_aux_in[5:4], imaginary_aux_in[2:0]})
        else $error("mode fields differ from the defined word");
    chk_scale_overlap: assert property (
        def_hold |-> later_pass_shift_out == (imaginary_aux_in[3] ? 2'h2 : 2'h3) && dual_source_out == (ovl >= 3'h5)
        && overlap_out == ((ovl inside {3'h1, 3'h2, 3'h6}) ? 2'h1 : (ovl inside {3'h3, 3'h4, 3'h7}) ? 2'h2 : 2'h0))
        else $error("shift or overlap decode wrong");
    chk_no_load_define: assert property (
        mode_define_strobe_in [*7] |-> !$rose(load_window_flag_out)) else $error("load began during define");
    chk_drive_with_valid: assert property (
        output_valid_flag_out |-> output_drive_enable_out) else $error("valid flag without drivers");
    chk_dump_base: assert property (
        $rose(output_drive_enable_out) |-> dump_index_out == ((dump_size_out == 2'h2) ? half_n : 10'h0))
        else $error("dump started at wrong bin");
    chk_test_mode: assert property (
        test_mode_out == (size_code_out == 3'h0 && window_sel_out != 2'h0)) else $error("test mode decode wrong");
    chk_real_inverse: assert property (
        real_data_out == size_code_out[2] && inverse_out == (window_sel_out == 2'h3)) else $error("type decode wrong");
    chk_seq_force: assert property (
        sequential_out == (size_code_out inside {3'h3, 3'h6} || system_config_out == 2'h2))
        else $error("sequential decode wrong");
endmodule // fft_mode_control_decode_chk
bind fft_mode_control_decode fft_mode_control_decode_chk fft_mode_control_decode_chk_i (.*);

// >>> testbench/fft_far_side.sv
// Far side of the FFT block: mode host, sample source and result consumer
// Assumes the block's system clock; commands arrive just after an edge
module fft_far_side (
    input  wire logic        clk_in,      // System clock
    input  wire logic        def_go_in,   // Start a define
    input  wire logic [15:0] word_in,     // Mode word
    input  wire logic        go_in,       // Start strobe bursts
    input  wire logic [10:0] in_n_in,     // Input strobes
    input  wire logic [10:0] out_n_in,    // Output strobes
    output logic             define_out,  // Define strobe
    output logic [15:0]      aux_out,     // Aux pins
    output logic             in_stb_out,  // Input strobe
    output logic             out_stb_out, // Output strobe
    output logic [15:0]      sample_out,  // Real sample
    output logic             ready_out,   // Consumer ready
    output logic             busy_out     // Work pending
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [3:0]  dcnt = 4'h0;
    logic [10:0] ni = 11'h0;
    logic [10:0] no = 11'h0;
    logic [2:0]  ph = 3'h0;
    initial aux_out = 16'h0;
    initial sample_out = 16'h0100;
    assign in_stb_out  = ph[2] && ni != 11'h0;
    assign out_stb_out = ph[2] && no != 11'h0;
    assign define_out  = dcnt != 4'h0;
    assign ready_out   = ph[0]; // Slow consumer
    assign busy_out    = define_out || ni != 11'h0 || no != 11'h0;
    // Eight-cycle strobe slots, define for ten cycles
    always @(posedge clk_in) begin
        ph <= go_in ? 3'h0 : ph + 3'h1;
        if (go_in) begin
            ni <= in_n_in;
            no <= out_n_in;
        end else if (ph == 3'h7) begin
            if (ni != 11'h0) begin
                ni <= ni - 11'h1;
                sample_out <= sample_out + 16'h0123;
            end
            if (no != 11'h0) no <= no - 11'h1;
        end
        if (def_go_in) begin
            dcnt <= 4'ha;
            aux_out <= word_in;
        end else if (dcnt != 4'h0) begin
            dcnt <= dcnt - 4'h1;
            if (dcnt == 4'h1) aux_out <= ~aux_out;
        end
    end
endmodule // fft_far_side

// >>> testbench/fft_mode_control_decode_bench.sv
// Testbench of the FFT mode block: decode, load, dump, delayed and held flag
// Assumes the far-side model drives the pins; 10 MHz clock
module fft_mode_control_decode_bench;
    timeunit 1ns;
    timeprecision 1ns;
    logic        clk_in = 1'b0, rst_in = 1'b1, input_load_enable_in = 1'b0, def_go = 1'b0, go = 1'b0, busy;
    logic        mode_define_strobe_in, input_sample_strobe_in, output_sample_strobe_in, weighted_ready_in;
    logic [15:0] imaginary_aux_in, sample_in, weighted_sample_out, w = 16'h0;
    logic        weighted_valid_out, load_window_flag_out, output_valid_flag_out, output_drive_enable_out;
    logic        real_data_out, inverse_out, dual_source_out, sequential_out, test_mode_out;
    logic [9:0]  dump_index_out;
    logic [2:0]  size_code_out;
    logic [1:0]  later_pass_shift_out, window_sel_out, overlap_out, system_config_out, dump_size_out;
    logic [10:0] in_n = 11'h0, out_n = 11'h0;
    int          err_total = 0, n_compared = 0, n_words = 0;
    fft_mode_control_decode fft_mode_control_decode_i (.*);
    fft_far_side fft_far_side_i (.clk_in(clk_in), .def_go_in(def_go), .word_in(w), .go_in(go), .in_n_in(in_n),
        .out_n_in(out_n), .define_out(mode_define_strobe_in), .aux_out(imaginary_aux_in),
        .in_stb_out(input_sample_strobe_in), .out_stb_out(output_sample_strobe_in), .sample_out(sample_in),
        .ready_out(weighted_ready_in), .busy_out(busy));
    always #50 clk_in = ~clk_in;
    // Counts words taken from the weighted stream
    always @(posedge clk_in) if (weighted_valid_out && weighted_ready_in) n_words <= n_words + 1;
    task automatic tick(input int n);
        repeat (n) @(posedge clk_in);
    endtask
    task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            err_total++;
            $display("Error at %0t ns: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic idle;
        tick(2);
        for (int k = 0; k < 5000 && busy; k++) tick(1);
        tick(8);
    endtask
    task automatic send(input logic [15:0] word);
        @(posedge clk_in);
        def_go <= 1'b1;
        w <= word;
        @(posedge clk_in);
        def_go <= 1'b0;
        idle();
    endtask
    task automatic burst(input logic [10:0] ni, input logic [10:0] no);
        @(posedge clk_in);
        go <= 1'b1;
        in_n <= ni;
        out_n <= no;
        @(posedge clk_in);
        go <= 1'b0;
        idle();
    endtask
    task automatic load_edge;
        @(posedge clk_in);
        input_load_enable_in <= 1'b1;
        tick(8);
        input_load_enable_in <= 1'b0;
    endtask
    task automatic t_decode;
        logic [2:0] s, o;
        logic [1:0] d, win;
        logic [31:0] e;
        for (int i = 0; i < 8; i++) begin
            s = (i == 7) ? 3'h6 : 3'(i);
            o = 3'(i);
            d = 2'(i);
            win = d + 2'h1;
            send({1'b0, d, 2'b00, d, o, win, d[0], s});
            e = {14'h0, s, s[2], d[0] ? 2'h2 : 2'h3, win == 2'h3, win,
                (o inside {3'h1, 3'h2, 3'h6}) ? 2'h1 : (o inside {3'h3, 3'h4, 3'h7}) ? 2'h2 : 2'h0,
                o >= 3'h5, d, s == 3'h3 || s == 3'h6 || d == 2'h2, s == 3'h0 && win != 2'h0, d};
            cmp({14'h0, size_code_out, real_data_out, later_pass_shift_out, inverse_out, window_sel_out, overlap_out,
                dual_source_out, system_config_out, sequential_out, test_mode_out, dump_size_out}, e);
        end
    endtask
    task automatic t_plain;
        send(16'h5200);
        cmp(32'(load_window_flag_out), 32'h1);
        burst(11'd16, 11'd0);
        send(16'h6000);
        load_edge();
        cmp(32'(load_window_flag_out), 32'h1);
        burst(11'd16, 11'd0);
        cmp(32'({output_valid_flag_out, output_drive_enable_out, load_window_flag_out, dump_index_out}), 32'h1800);
        burst(11'd0, 11'd16);
        cmp(32'({output_valid_flag_out, output_drive_enable_out}), 32'h0);
        cmp(32'(n_words), 32'd32);
        cmp(32'(weighted_sample_out), ((32'h0100 + 32'd31 * 32'h0123) * 32'h7fff) >> 15);
    endtask
    task automatic t_delay;
        send(16'h6801);
        load_edge();
        burst(11'd64, 11'd0);
        cmp(32'({output_drive_enable_out, output_valid_flag_out}), 32'h2);
        burst(11'd0, 11'd23);
        cmp(32'(output_valid_flag_out), 32'h0);
        burst(11'd0, 11'd1);
        cmp(32'({output_valid_flag_out, dump_index_out}), 32'h418);
        burst(11'd0, 11'd40);
        cmp(32'({output_drive_enable_out, output_valid_flag_out}), 32'h0);
    endtask
    task automatic t_hold;
        send(16'h8000);
        load_edge();
        burst(11'd16, 11'd0);
        burst(11'd0, 11'd8);
        cmp(32'({output_valid_flag_out, output_drive_enable_out}), 32'h3);
        load_edge();
        cmp(32'(output_valid_flag_out), 32'h0);
    endtask
    task automatic close_out;
        $display("Compared %0d, errors %0d", n_compared, err_total);
        if (err_total == 0 && n_compared > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    initial begin
        tick(3);
        rst_in <= 1'b0;
        tick(2);
        cmp(32'({later_pass_shift_out, output_valid_flag_out, load_window_flag_out}), 32'hc);
        t_decode();
        t_plain();
        t_delay();
        t_hold();
        close_out();
    end
    // Watchdog against a hung handshake
    initial begin
        #2000000;
        err_total++;
        close_out();
    end
endmodule // fft_mode_control_decode_bench
